// ---- rtl/pmc_power_mode_clock_control.sv ----
`timescale 1ns/1ps
module pmc_power_mode_clock_control
    import pmc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // sleep instruction and wake events
    input wire logic sleep_exec_in,
    input wire logic wake_osc_start_in,
    input wire logic wake_to_external_in,
    input wire logic switch_start_in,
    input wire logic wdt_onchip_clock_in,
    // oscillator cycle ticks, asynchronous to core clock
    input wire logic osc_ext_tick_in,
    input wire logic osc_rc_tick_in,
    // mode and clock results
    output pmc_mode_t target_mode_out,
    output logic [2:0] active_div_out,
    output logic [1:0] sub_div_out,
    output logic clock_release_out,
    output logic noise_sample_tick_out,
    output logic [10:0] module_halt_out
);
    // power mode and clock control
    // - holds the power control and module halt registers
    // - decodes the sleep target mode at each sleep pulse
    // - latches the clock dividers at each sleep pulse
    // - times oscillator settling on wake and on clock switch
    // - makes the watch clock sampling strobe
    // - drives the per module halt lines

    // register map, one byte per aligned word, upper bytes read zero
    // 0x00 ctrl_one: power control one
    //   bit 7 software standby, picks standby on sleep
    //   bits 6:4 low wait select bits
    //   bit 3 noise sample rate select
    //   bits 2:0 reserved, read zero
    // 0x04 ctrl_two: power control two
    //   bit 7 sleep variant select
    //   bit 6 low speed on
    //   bit 5 direct transition on
    //   bits 4:2 active divider code
    //   bits 1:0 sub divider code
    // 0x08 ctrl_three: power control three
    //   bit 7 top wait select bit, resets to one
    //   bits 6:0 reserved, read zero
    // 0x0c halt_one: module halt one
    //   bit 6 i2c unit
    //   bit 5 serial interface a
    //   bit 3 watchdog
    //   bit 1 timer v
    //   bit 0 real-time clock
    //   bits 7, 4, 2 reserved, read zero
    // 0x10 halt_two: module halt two
    //   bit 7 serial interface b
    //   bit 4 timer b
    //   bit 0 pwm
    //   bits 6:5 and 3:1 reserved, read zero
    // 0x14 halt_four: module halt four
    //   bit 7 timer c
    //   bit 6 adc
    //   bit 5 timer d0
    //   bits 4:0 reserved, read zero
    // 0x18 status: target mode, read only
    // any other offset reads zero, writes are dropped

    // register storage
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] ctrl_three;
    logic [7:0] halt_one;
    logic [7:0] halt_two;
    logic [7:0] halt_four;

    // data phase capture
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] rd_data;

    // tick synchronisers and edges
    logic [2:0] ext_sync;
    logic [2:0] rc_sync;
    logic ext_edge;
    logic rc_edge;

    // wait counter
    logic [17:0] wait_cnt;
    logic wait_busy;
    logic wait_use_ext;
    logic wait_divided;
    logic [5:0] pre_cnt;
    logic [5:0] div_limit;
    logic [17:0] wait_cycles;
    logic count_tick;
    logic [3:0] noise_cnt;
    logic [3:0] next_noise_cnt;
    logic addr_phase;

    // accepted address phase
    assign addr_phase = hsel_in && htrans_in[1] && hready_in;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    // bus timing
    // - no wait states: hreadyout is tied high, responses are always okay
    // - write: address phase captured, data taken in the next cycle
    // - read: data registered at the address phase, stands in the data phase
    // - hsize is not decoded; every access is a whole word, low byte used
    // - back to back transfers are accepted
    // register write data phase tracking
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready_in) begin
            wr_pend <= addr_phase && hwrite_in;
            wr_addr <= haddr_in;
        end
    end

    // write path
    // each register keeps only its defined bits; reserved bits are
    // masked on the way in, so they always read zero
    // ctrl_two has no reserved bits and takes the whole byte
    // a write to status or an unmapped offset changes nothing
    // register writes; reserved bits held at 0
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ctrl_one <= PMC_RST_CTRL_ONE;
            ctrl_two <= PMC_RST_CTRL_TWO;
            ctrl_three <= PMC_RST_CTRL_THREE;
            halt_one <= PMC_RST_HALT;
            halt_two <= PMC_RST_HALT;
            halt_four <= PMC_RST_HALT;
        end else if (wr_pend) begin
            case (wr_addr)
                PMC_OFS_CTRL_ONE: ctrl_one <= hwdata_in[7:0] & PMC_MASK_CTRL_ONE;
                PMC_OFS_CTRL_TWO: ctrl_two <= hwdata_in[7:0];
                PMC_OFS_CTRL_THREE: ctrl_three <= hwdata_in[7:0] & PMC_MASK_CTRL_THREE;
                PMC_OFS_HALT_ONE: halt_one <= hwdata_in[7:0] & PMC_MASK_HALT_ONE;
                PMC_OFS_HALT_TWO: halt_two <= hwdata_in[7:0] & PMC_MASK_HALT_TWO;
                PMC_OFS_HALT_FOUR: halt_four <= hwdata_in[7:0] & PMC_MASK_HALT_FOUR;
                default: ;
            endcase
        end
    end

    // read path
    // the mux looks at the address phase address; its result is
    // registered and then stands until the next read address phase
    // writes in the same data phase do not disturb the held read data
    // read mux, unmapped reads zero
    always_comb begin
        case (haddr_in)
            PMC_OFS_CTRL_ONE: rd_data = ctrl_one;
            PMC_OFS_CTRL_TWO: rd_data = ctrl_two;
            PMC_OFS_CTRL_THREE: rd_data = ctrl_three;
            PMC_OFS_HALT_ONE: rd_data = halt_one;
            PMC_OFS_HALT_TWO: rd_data = halt_two;
            PMC_OFS_HALT_FOUR: rd_data = halt_four;
            PMC_OFS_STATUS: rd_data = {5'h00, target_mode_out};
            default: rd_data = 8'h00;
        endcase
    end

    // read data registered for the data phase
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (addr_phase && !hwrite_in) begin
            hrdata_out <= {24'h00_0000, rd_data};
        end
    end

    // sleep target table
    // direct  standby  variant  low speed -> mode
    //   1        x        x        0      -> active, direct
    //   1        x        x        1      -> subactive, direct
    //   0        1        x        x      -> standby
    //   0        0        1        x      -> subsleep
    //   0        0        0        x      -> sleep
    // the mode is held until the next sleep pulse
    // sleep target decode
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            target_mode_out <= PMC_MODE_ACTIVE;
        end else if (sleep_exec_in) begin
            if (ctrl_two[PMC_BIT_DIRECT]) begin
                target_mode_out <= ctrl_two[PMC_BIT_LOW_SPEED] ? PMC_MODE_SUBACTIVE
                                                               : PMC_MODE_ACTIVE;
            end else if (ctrl_one[PMC_BIT_STANDBY]) begin
                target_mode_out <= PMC_MODE_STANDBY;
            end else if (ctrl_two[PMC_BIT_SLEEP_SEL]) begin
                target_mode_out <= PMC_MODE_SUBSLEEP;
            end else begin
                target_mode_out <= PMC_MODE_SLEEP;
            end
        end
    end

    // divider codes in effect
    // active: 0xx undivided, 100 /8, 101 /16, 110 /32, 111 /64
    // sub: 00 /8, 01 /4, 1x /2 of the watch clock
    // software may rewrite the fields at any time; the running clock
    // keeps the old ratio until the next sleep pulse, so a half written
    // pair of fields never reaches the clock tree
    // dividers latched only at the sleep instruction
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            active_div_out <= 3'h0;
            sub_div_out <= 2'h0;
        end else if (sleep_exec_in) begin
            active_div_out <= ctrl_two[PMC_BIT_ACT_DIV +: 3];
            sub_div_out <= ctrl_two[1:0];
        end
    end

    // wait codes, top bit then low three bits
    // x000 8192, x001 16384, x010 32768, x011 65536, x100 131072
    // 1101 1024, 1110 128, 1111 16
    // 0101 4096, 0110 2048, 0111 512
    // the top bit only matters for the three highest low codes
    // wait count decode
    always_comb begin
        case (ctrl_one[PMC_BIT_WAIT_LO +: 3])
            3'h0: wait_cycles = PMC_WAIT_8K;
            3'h1: wait_cycles = PMC_WAIT_16K;
            3'h2: wait_cycles = PMC_WAIT_32K;
            3'h3: wait_cycles = PMC_WAIT_64K;
            3'h4: wait_cycles = PMC_WAIT_128K;
            3'h5: wait_cycles = ctrl_three[PMC_BIT_WAIT_TOP] ? PMC_WAIT_1K : PMC_WAIT_4K;
            3'h6: wait_cycles = ctrl_three[PMC_BIT_WAIT_TOP] ? PMC_WAIT_128 : PMC_WAIT_2K;
            default: wait_cycles = ctrl_three[PMC_BIT_WAIT_TOP] ? PMC_WAIT_16 : PMC_WAIT_512;
        endcase
    end

    // prescaler limit, the divide ratio minus one
    // an undivided setting gives limit zero, one count per rc tick
    // active divider ratio minus one
    always_comb begin
        case (active_div_out)
            3'h4: div_limit = 6'd7;
            3'h5: div_limit = 6'd15;
            3'h6: div_limit = 6'd31;
            3'h7: div_limit = 6'd63;
            default: div_limit = 6'd0;
        endcase
    end

    // oscillator ticks arrive from other clock domains; each passes two
    // flops before the edge detect; the third flop only holds the old
    // level for the edge compare
    // the tick must stay high and low for at least one core cycle each,
    // or edges are lost and the waits run long
    // reset clears all stages to the idle low level, so no false edge
    // oscillator tick synchronisers; stage 0 read only by stage 1
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ext_sync <= 3'h0;
            rc_sync <= 3'h0;
        end else begin
            ext_sync <= {ext_sync[1:0], osc_ext_tick_in};
            rc_sync <= {rc_sync[1:0], osc_rc_tick_in};
        end
    end
    assign ext_edge = ext_sync[1] && !ext_sync[2];
    assign rc_edge = rc_sync[1] && !rc_sync[2];

    // count source selection
    // wake to external: external ticks, undivided
    // wake to rc: rc ticks, undivided
    // clock switch: rc ticks, one count per divider period
    // the prescaler compare uses the latched divider limit
    // count source: wake uses undivided new source, switch uses divided rc
    assign count_tick = wait_use_ext ? ext_edge
                      : (rc_edge && (!wait_divided || pre_cnt == div_limit));

    // wait counter behaviour
    // - a wake start loads the decoded count and drops clock release
    // - wake waits count every synced tick of the new source, undivided
    // - switch waits count rc ticks through the active divider prescaler
    // - the divider used is the one latched at the last sleep pulse
    // - release rises the cycle after the last counted tick
    // - a start seen while busy is ignored, the running wait wins
    // - a wake start and a switch start in one cycle: wake wins
    // hazard: a dead source oscillator keeps the wait busy forever;
    // the counter has no watchdog of its own by design
    // the prescaler restarts from zero on every start, so a switch
    // wait is a whole number of divided cycles, never a partial one
    // wait down counter and clock release
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wait_cnt <= 18'h0_0000;
            wait_busy <= 1'b0;
            wait_use_ext <= 1'b0;
            wait_divided <= 1'b0;
            pre_cnt <= 6'd0;
        end else if (!wait_busy && wake_osc_start_in) begin
            wait_cnt <= wait_cycles;
            wait_busy <= 1'b1;
            wait_use_ext <= wake_to_external_in;
            wait_divided <= 1'b0;
            pre_cnt <= 6'd0;
        end else if (!wait_busy && switch_start_in) begin
            wait_cnt <= wait_cycles;
            wait_busy <= 1'b1;
            wait_use_ext <= 1'b0;
            wait_divided <= 1'b1;
            pre_cnt <= 6'd0;
        end else if (wait_busy) begin
            if (wait_divided && rc_edge) begin
                pre_cnt <= (pre_cnt == div_limit) ? 6'd0 : pre_cnt + 6'd1;
            end
            if (count_tick) begin
                wait_cnt <= wait_cnt - 18'h0_0001;
                if (wait_cnt == 18'h0_0001) begin
                    wait_busy <= 1'b0;
                end
            end
        end
    end
    assign clock_release_out = !wait_busy;

    // noise sample strobe
    // counts rc ticks and pulses once per 16 (select 0) or 4 (select 1)
    // a count left above the new limit after a select change wraps at
    // once instead of running round the whole four bit range
    // the strobe lasts exactly one core cycle
    // watch clock sampling strobe from rc ticks
    always_comb begin
        next_noise_cnt = noise_cnt + 4'h1;
        if (noise_cnt >= (ctrl_one[PMC_BIT_NOISE] ? PMC_NOISE_DIV4 : PMC_NOISE_DIV16)) begin
            next_noise_cnt = 4'h0;
        end
    end

    // sample counter and strobe register
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            noise_cnt <= 4'h0;
            noise_sample_tick_out <= 1'b0;
        end else begin
            noise_sample_tick_out <= 1'b0;
            if (rc_edge) begin
                noise_cnt <= next_noise_cnt;
                noise_sample_tick_out <= (next_noise_cnt == 4'h0);
            end
        end
    end

    // module halt bit order on the output
    // [10] timer c  [9] adc  [8] timer d0  [7] serial b  [6] timer b
    // [5] pwm  [4] i2c  [3] serial a  [2] watchdog  [1] timer v  [0] rtc
    // the watchdog halt is dropped while it counts the on-chip clock,
    // so the watchdog cannot be stopped by software in that setting
    // module halt outputs
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            module_halt_out <= 11'h000;
        end else begin
            module_halt_out <= {halt_four[7:5], halt_two[7], halt_two[4], halt_two[0],
                                halt_one[6], halt_one[5],
                                halt_one[PMC_BIT_HALT_WDT] && !wdt_onchip_clock_in,
                                halt_one[1], halt_one[0]};
        end
    end
endmodule

// ---- pkg/pmc_pkg.sv ----
package pmc_pkg;
    // register byte offsets
    localparam logic [7:0] PMC_OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] PMC_OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] PMC_OFS_CTRL_THREE = 8'h08;
    localparam logic [7:0] PMC_OFS_HALT_ONE = 8'h0c;
    localparam logic [7:0] PMC_OFS_HALT_TWO = 8'h10;
    localparam logic [7:0] PMC_OFS_HALT_FOUR = 8'h14;
    localparam logic [7:0] PMC_OFS_STATUS = 8'h18;
    // writable bit masks (reserved bits read 0)
    localparam logic [7:0] PMC_MASK_CTRL_ONE = 8'hf8;
    localparam logic [7:0] PMC_MASK_CTRL_THREE = 8'h80;
    localparam logic [7:0] PMC_MASK_HALT_ONE = 8'h6b;
    localparam logic [7:0] PMC_MASK_HALT_TWO = 8'h91;
    localparam logic [7:0] PMC_MASK_HALT_FOUR = 8'he0;
    // reset values
    localparam logic [7:0] PMC_RST_CTRL_ONE = 8'h00;
    localparam logic [7:0] PMC_RST_CTRL_TWO = 8'h00;
    localparam logic [7:0] PMC_RST_CTRL_THREE = 8'h80;
    localparam logic [7:0] PMC_RST_HALT = 8'h00;
    // field positions
    localparam int PMC_BIT_STANDBY = 7;
    localparam int PMC_BIT_WAIT_LO = 4;
    localparam int PMC_BIT_NOISE = 3;
    localparam int PMC_BIT_SLEEP_SEL = 7;
    localparam int PMC_BIT_LOW_SPEED = 6;
    localparam int PMC_BIT_DIRECT = 5;
    localparam int PMC_BIT_ACT_DIV = 2;
    localparam int PMC_BIT_WAIT_TOP = 7;
    localparam int PMC_BIT_HALT_WDT = 3;
    // wait cycle counts
    localparam logic [17:0] PMC_WAIT_8K = 18'h0_2000;
    localparam logic [17:0] PMC_WAIT_16K = 18'h0_4000;
    localparam logic [17:0] PMC_WAIT_32K = 18'h0_8000;
    localparam logic [17:0] PMC_WAIT_64K = 18'h1_0000;
    localparam logic [17:0] PMC_WAIT_128K = 18'h2_0000;
    localparam logic [17:0] PMC_WAIT_1K = 18'h0_0400;
    localparam logic [17:0] PMC_WAIT_128 = 18'h0_0080;
    localparam logic [17:0] PMC_WAIT_16 = 18'h0_0010;
    localparam logic [17:0] PMC_WAIT_4K = 18'h0_1000;
    localparam logic [17:0] PMC_WAIT_2K = 18'h0_0800;
    localparam logic [17:0] PMC_WAIT_512 = 18'h0_0200;
    // noise sampling divisors minus one
    localparam logic [3:0] PMC_NOISE_DIV16 = 4'hf;
    localparam logic [3:0] PMC_NOISE_DIV4 = 4'h3;
    // sleep target modes
    typedef enum logic [2:0] {
        PMC_MODE_ACTIVE,
        PMC_MODE_SLEEP,
        PMC_MODE_SUBSLEEP,
        PMC_MODE_STANDBY,
        PMC_MODE_SUBACTIVE
    } pmc_mode_t;
endpackage

// ---- tb/pmc_monitor.sv ----
`timescale 1ns/1ps
module pmc_monitor
    import pmc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // event inputs
    input wire logic sleep_exec_in,
    input wire logic wake_osc_start_in,
    input wire logic wdt_onchip_clock_in,
    // bus outputs
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    // mode and clock outputs
    input pmc_mode_t target_mode_out,
    input wire logic [2:0] active_div_out,
    input wire logic [1:0] sub_div_out,
    input wire logic clock_release_out,
    input wire logic noise_sample_tick_out,
    input wire logic [10:0] module_halt_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    // zero wait states, always okay
    a_bus_ready: assert property (hreadyout_out && !hresp_out)
        else $error("bus answer not ready or not okay");
    a_rdata_upper: assert property (hrdata_out[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    // watchdog never halted while on the on-chip clock
    a_wdt_runs: assert property ((wdt_onchip_clock_in && $past(wdt_onchip_clock_in)) |-> !module_halt_out[2])
        else $error("watchdog halted on on-chip clock");
    a_noise_pulse: assert property (noise_sample_tick_out |=> !noise_sample_tick_out)
        else $error("noise tick longer than one cycle");
    // a wake start withdraws the clocks within three cycles; any withdrawal lasts at least eight cycles
    a_wait_starts: assert property ((wake_osc_start_in && clock_release_out) |-> ##[1:3] !clock_release_out)
        else $error("wake start did not hold clocks");
    a_wait_min: assert property ($fell(clock_release_out) |-> !clock_release_out [*8])
        else $error("wait released too early");
    // dividers and mode change only on a sleep instruction
    a_div_hold: assert property (!sleep_exec_in |=> $stable(active_div_out) && $stable(sub_div_out))
        else $error("divider changed without sleep");
    a_mode_hold: assert property (!sleep_exec_in |=> $stable(target_mode_out))
        else $error("mode changed without sleep");

    // main scenarios
    c_noise: cover property (noise_sample_tick_out);
    c_release: cover property ($rose(clock_release_out));
    c_sleep: cover property (sleep_exec_in);
    c_wdt: cover property (wdt_onchip_clock_in && !module_halt_out[2]);
endmodule

// ---- tb/pmc_power_mode_clock_control_tb.sv ----
`timescale 1ns/1ps
bind pmc_power_mode_clock_control pmc_monitor i_mon (.core_clk_in, .rst_in, .sleep_exec_in,
    .wake_osc_start_in, .wdt_onchip_clock_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .target_mode_out, .active_div_out, .sub_div_out, .clock_release_out,
    .noise_sample_tick_out, .module_halt_out);
module pmc_power_mode_clock_control_tb
    import pmc_pkg::*;
();
    logic core_clk_in = 1'b0, rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
    logic sleep_exec_in = 1'b0, wake_osc_start_in = 1'b0, switch_start_in = 1'b0;
    logic wake_to_external_in = 1'b0, wdt_onchip_clock_in = 1'b0, rc_on = 1'b1, ext_on = 1'b0;
    logic osc_ext_tick_in = 1'b0, osc_rc_tick_in = 1'b0, hready_in;
    logic [7:0] haddr_in = 8'h00;
    logic [1:0] htrans_in = 2'b00;
    logic [2:0] hsize_in = 3'b010, active_div_out, pa = 3'b000;
    logic [31:0] hwdata_in = 32'h0000_0000, hrdata_out, rd;
    logic hreadyout_out, hresp_out, clock_release_out, noise_sample_tick_out;
    pmc_mode_t target_mode_out;
    logic [1:0] sub_div_out;
    logic [10:0] module_halt_out;
    int n_errors = 0, total_checks = 0, cnt;
    // register map, reset values and readable bits (last entry unmapped)
    localparam logic [7:0] ADR [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
    localparam logic [7:0] RST [7] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MSK [7] = '{8'hf8, 8'hff, 8'h80, 8'h6b, 8'h91, 8'he0, 8'h00};
    // sleep settings and the mode each selects
    localparam logic [7:0] C1 [5] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    localparam logic [7:0] C2 [5] = '{8'h00, 8'h9d, 8'h16, 8'h38, 8'h73};
    localparam pmc_mode_t MD [5] = '{PMC_MODE_SLEEP, PMC_MODE_SUBSLEEP, PMC_MODE_STANDBY,
        PMC_MODE_ACTIVE, PMC_MODE_SUBACTIVE};
    // wait codes, cycle counts and source oscillator
    localparam logic [7:0] W3 [6] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h80};
    localparam logic [7:0] W1 [6] = '{8'h00, 8'h50, 8'h60, 8'h70, 8'h60, 8'h70};
    localparam int WN [6] = '{8192, 1024, 128, 512, 2048, 16};
    localparam logic WX [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    assign hready_in = hreadyout_out;
    always #50 core_clk_in = ~core_clk_in;
    // oscillator cycles, one rising edge every two core cycles
    always @(posedge core_clk_in) begin
        if (rc_on) osc_rc_tick_in <= ~osc_rc_tick_in;
        if (ext_on) osc_ext_tick_in <= ~osc_ext_tick_in;
    end

    pmc_power_mode_clock_control i_dut (.core_clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in,
        .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
        .sleep_exec_in, .wake_osc_start_in, .wake_to_external_in, .switch_start_in,
        .wdt_onchip_clock_in, .osc_ext_tick_in, .osc_rc_tick_in, .target_mode_out,
        .active_div_out, .sub_div_out, .clock_release_out, .noise_sample_tick_out,
        .module_halt_out);

    task automatic tally_and_finish();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    // next rising edge with hready high, bounded
    task automatic edge_rdy();
        int k;
        k = 0;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (hreadyout_out !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    // one single ahb-lite word transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_in <= 1'b1;
        htrans_in <= 2'b10;
        haddr_in <= a;
        hwrite_in <= w;
        edge_rdy();
        htrans_in <= 2'b00;
        hwdata_in <= d;
        edge_rdy();
        rd = hrdata_out;
    endtask
    // let edges pass, then look at settled outputs
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_in);
        #10;
    endtask
    // one-cycle pulse: 0 sleep, 1 wake start, 2 clock switch
    task automatic pulse(input int which);
        case (which)
            0: sleep_exec_in <= 1'b1;
            1: wake_osc_start_in <= 1'b1;
            default: switch_start_in <= 1'b1;
        endcase
        @(posedge core_clk_in);
        sleep_exec_in <= 1'b0;
        wake_osc_start_in <= 1'b0;
        switch_start_in <= 1'b0;
        @(posedge core_clk_in);
    endtask
    // cycles until clocks are released
    task automatic meas();
        cnt = 0;
        do begin
            idle(1);
            cnt++;
        end while (clock_release_out !== 1'b1 && cnt < 40000);
        if (cnt >= 40000) begin
            n_errors++;
            tally_and_finish();
        end
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge core_clk_in);
        rst_in <= 1'b0;
        idle(1);
        chk("release", 32'h0000_0001, 32'(clock_release_out));
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, ADR[i], 32'h0000_0000);
            chk("reset value", 32'(RST[i]), rd);
            xfer(1'b1, ADR[i], 32'hffff_ffff);
            xfer(1'b0, ADR[i], 32'h0000_0000);
            chk("readback", 32'(MSK[i]), rd);
        end
        idle(2);
        chk("halt all", 32'h0000_07ff, 32'(module_halt_out));
        wdt_onchip_clock_in <= 1'b1;
        idle(3);
        chk("halt wdt", 32'h0000_07fb, 32'(module_halt_out));
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, 8'h00, 32'(C1[i]));
            xfer(1'b1, 8'h04, 32'(C2[i]));
            idle(1);
            chk("div before sleep", 32'(pa), 32'(active_div_out));
            pulse(0);
            idle(1);
            chk("mode", 32'(MD[i]), 32'(target_mode_out));
            chk("active div", 32'(C2[i][4:2]), 32'(active_div_out));
            chk("sub div", 32'(C2[i][1:0]), 32'(sub_div_out));
            xfer(1'b0, PMC_OFS_STATUS, 32'h0000_0000);
            chk("mode reg", 32'(MD[i]), rd);
            pa = C2[i][4:2];
        end
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, 8'h00, 32'h0000_0070 + 32'(i * 8));
            cnt = 0;
            repeat (320) begin
                idle(1);
                if (noise_sample_tick_out === 1'b1) cnt++;
            end
            chk_rng("noise ticks", i ? 39 : 9, i ? 41 : 11, cnt);
        end
        pulse(2);
        meas();
        chk_rng("switch wait", 250, 530, cnt);
        for (int i = 0; i < 6; i++) begin
            xfer(1'b1, 8'h08, 32'(W3[i]));
            xfer(1'b1, 8'h00, 32'(W1[i]));
            rc_on <= !WX[i];
            ext_on <= WX[i];
            wake_to_external_in <= WX[i];
            pulse(1);
            meas();
            chk_rng("wake wait", 2 * WN[i] - 4, 2 * WN[i] + 12, cnt);
            rc_on <= 1'b1;
            ext_on <= 1'b0;
        end
        tally_and_finish();
    end
endmodule
